/* rtl/uart_evt_defs.svh */
// Constants for the serial channel event-timing block.
// Assumes a 100 MHz system clock and a byte-wide host strobe interface.
`ifndef UART_EVT_DEFS_SVH
`define UART_EVT_DEFS_SVH

// ==========================================================================
// Clock and times
`define CLK_PERIOD_NS       10
`define STRB_CLR_NS         70
`define STRB_CLR_CYC        ((`STRB_CLR_NS) / (`CLK_PERIOD_NS))
`define RX_READY_FLAG_CLR_US        1
`define RX_READY_FLAG_CLR_CYC       ((`RX_READY_FLAG_CLR_US * 1000) / (`CLK_PERIOD_NS))

// ==========================================================================
// Baud timing in 16x ticks, divisor reset, FIFO size and character length
`define OVERSAMPLE          5'h10
`define OVS_MID             4'h7
`define OVS_LAST            4'hf
`define TX_START_MIN        5'h08
`define TX_START_MAX        5'h18
`define TX_READY_FLAG_DROP_MAX      5'h10
`define DIV_RESET           16'h0001
`define FIFO_DEPTH          64
`define FIFO_AW             6
`define BITS_PER_CHAR       4'h8
`define LAST_BIT            3'h7

// ==========================================================================
// Interrupt identification codes
`define IDENT_NONE          4'h1
`define IDENT_TX            4'h2
`define IDENT_RX            4'h4

`endif

/* rtl/uart_evt_pkg.sv */
// Types shared by the serial channel event-timing block.
// Assumes uart_evt_defs.svh is compiled alongside.
package uart_evt_pkg;

	// ======================================================================
	// Host strobe group
	typedef struct packed {
		logic       read_strobe_n;
		logic       write_strobe_n;
		logic       sel_data;
		logic       sel_status;
		logic [7:0] wdata;
	} host_req_t;

	// ======================================================================
	// Status and event outputs
	typedef struct packed {
		logic       rx_ready_flag;
		logic       tx_ready_flag;
		logic       rx_irq;
		logic       tx_irq;
		logic [7:0] line_status_reg;
		logic [3:0] interrupt_ident_reg;
	} chan_status_t;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_WAIT,
		TX_SHIFT
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rx_state_t;

endpackage : uart_evt_pkg

/* rtl/baud_tick_gen.sv */
// 16x baud tick generator.
// Assumes a divisor of at least one from the host configuration pins.
`include "uart_evt_defs.svh"

module baud_tick_gen
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic [15:0] i_divisor,
	output logic             o_tick
);
	import uart_evt_pkg::*;

	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;

	// ======================================================================
	// Divider
	always_comb
	begin
		cnt_next  = cnt_reg + 16'h0001;
		tick_next = 1'b0;
		if (cnt_reg >= i_divisor - `DIV_RESET)
		begin
			cnt_next  = 16'h0000;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign o_tick = tick_reg;

endmodule : baud_tick_gen

/* rtl/uart_channel_event_timing.sv */
// One serial channel: 8N1 receiver and transmitter with host strobes.
// Assumes strobes synchronous to i_clk and held at least one clock.
`include "uart_evt_defs.svh"

module uart_channel_event_timing
(
	input  wire logic                      i_clk,
	input  wire logic                      i_srst,
	input  wire uart_evt_pkg::host_req_t   i_req,
	input  wire logic                      i_fifo_en,
	input  wire logic [15:0]               i_divisor,
	input  wire logic                      i_rx_en_irq,
	input  wire logic                      i_tx_en_irq,
	input  wire logic                      i_rx_line,
	output logic                           o_tx_line,
	output logic [7:0]                     o_rdata,
	output uart_evt_pkg::chan_status_t     o_status
);
	import uart_evt_pkg::*;

	logic tick;

	baud_tick_gen u_baud
	(
		.i_clk     (i_clk),
		.i_srst    (i_srst),
		.i_divisor (i_divisor),
		.o_tick    (tick)
	);

	// ======================================================================
	// Host strobe edges (taken on the falling edge of each strobe)
	logic rd_n_reg;
	logic wr_n_reg;
	logic rd_pulse;
	logic wr_pulse;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
		end
		else
		begin
			rd_n_reg <= i_req.read_strobe_n;
			wr_n_reg <= i_req.write_strobe_n;
		end
	end

	assign rd_pulse = rd_n_reg & ~i_req.read_strobe_n;
	assign wr_pulse = wr_n_reg & ~i_req.write_strobe_n;

	logic rd_data;
	logic rd_stat;
	logic wr_data;
	assign rd_data = rd_pulse & i_req.sel_data;
	assign rd_stat = rd_pulse & i_req.sel_status;
	assign wr_data = wr_pulse & i_req.sel_data;

	// ======================================================================
	// Receiver
	rx_state_t  rx_st_reg;
	rx_state_t  rx_st_next;
	logic [3:0] rx_ph_reg;
	logic [3:0] rx_ph_next;
	logic [2:0] rx_bit_reg;
	logic [2:0] rx_bit_next;
	logic [7:0] rx_sh_reg;
	logic [7:0] rx_sh_next;
	logic       rx_done;

	always_comb
	begin
		rx_st_next  = rx_st_reg;
		rx_ph_next  = rx_ph_reg;
		rx_bit_next = rx_bit_reg;
		rx_sh_next  = rx_sh_reg;
		rx_done     = 1'b0;
		if (tick)
		begin
			rx_ph_next = rx_ph_reg + 4'h1;
			case (rx_st_reg)
				RX_IDLE:
				begin
					rx_ph_next = 4'h0;
					if (!i_rx_line)
						rx_st_next = RX_START;
				end
				RX_START:
				begin
					if (rx_ph_reg == `OVS_MID)
					begin
						rx_ph_next = 4'h0;
						rx_bit_next = 3'h0;
						rx_st_next = i_rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					if (rx_ph_reg == `OVS_LAST)
					begin
						rx_sh_next = {i_rx_line, rx_sh_reg[7:1]};
						rx_bit_next = rx_bit_reg + 3'h1;
						if (rx_bit_reg == `LAST_BIT)
							rx_st_next = RX_STOP;
					end
				end
				RX_STOP:
				begin
					if (rx_ph_reg == `OVS_LAST)
					begin
						rx_st_next = RX_IDLE;
						rx_done    = 1'b1;
					end
				end
				default:
					rx_st_next = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			rx_st_reg  <= RX_IDLE;
			rx_ph_reg  <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_sh_reg  <= 8'h00;
		end
		else
		begin
			rx_st_reg  <= rx_st_next;
			rx_ph_reg  <= rx_ph_next;
			rx_bit_reg <= rx_bit_next;
			rx_sh_reg  <= rx_sh_next;
		end
	end

	// ======================================================================
	// Receive store: FIFO array, or single holding byte loaded one tick late
	logic [7:0]             rx_mem [`FIFO_DEPTH];
	logic [`FIFO_AW-1:0]    rx_wp_reg;
	logic [`FIFO_AW-1:0]    rx_wp_next;
	logic [`FIFO_AW-1:0]    rx_rp_reg;
	logic [`FIFO_AW-1:0]    rx_rp_next;
	logic [`FIFO_AW:0]      rx_cnt_reg;
	logic [`FIFO_AW:0]      rx_cnt_next;
	logic [7:0]             rx_holding_reg;
	logic [7:0]             rx_holding_next;
	logic                   hold_pend_reg;
	logic                   hold_pend_next;
	logic                   rx_push;
	logic                   rx_pop;
	logic                   overrun_reg;
	logic                   overrun_next;

	assign rx_push = rx_done & (rx_cnt_reg != 7'(`FIFO_DEPTH)) & i_fifo_en;
	assign rx_pop  = rd_data & (rx_cnt_reg != 7'h00);

	always_comb
	begin
		rx_wp_next      = rx_wp_reg;
		rx_rp_next      = rx_rp_reg;
		rx_cnt_next     = rx_cnt_reg;
		rx_holding_next = rx_holding_reg;
		hold_pend_next  = hold_pend_reg;
		overrun_next    = overrun_reg;
		if (i_fifo_en)
		begin
			if (rx_push)
				rx_wp_next = rx_wp_reg + 6'h01;
			if (rx_pop)
				rx_rp_next = rx_rp_reg + 6'h01;
			rx_cnt_next = rx_cnt_reg + 7'(rx_push) - 7'(rx_pop);
		end
		else
		begin
			if (rx_pop)
				rx_cnt_next = 7'h00;
			if (rx_done)
			begin
				rx_cnt_next    = 7'h01;
				hold_pend_next = 1'b1;
			end
			else if (hold_pend_reg && tick)
			begin
				rx_holding_next = rx_sh_reg;
				hold_pend_next  = 1'b0;
			end
		end
		if (rd_stat)
			overrun_next = 1'b0;
		if (rx_done && (i_fifo_en ? !rx_push : (rx_cnt_reg != 7'h00 && !rx_pop)))
			overrun_next = 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (rx_push)
			rx_mem[rx_wp_reg] <= rx_sh_reg;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			rx_wp_reg      <= 6'h00;
			rx_rp_reg      <= 6'h00;
			rx_cnt_reg     <= 7'h00;
			rx_holding_reg <= 8'h00;
			hold_pend_reg  <= 1'b0;
			overrun_reg    <= 1'b0;
		end
		else
		begin
			rx_wp_reg      <= rx_wp_next;
			rx_rp_reg      <= rx_rp_next;
			rx_cnt_reg     <= rx_cnt_next;
			rx_holding_reg <= rx_holding_next;
			hold_pend_reg  <= hold_pend_next;
			overrun_reg    <= overrun_next;
		end
	end

	// ======================================================================
	// Transmitter: single holding byte plus shifter
	tx_state_t  tx_st_reg;
	tx_state_t  tx_st_next;
	logic [7:0] tx_hold_reg;
	logic [7:0] tx_hold_next;
	logic       tx_full_reg;
	logic       tx_full_next;
	logic [9:0] tx_sh_reg;
	logic [9:0] tx_sh_next;
	logic [3:0] tx_ph_reg;
	logic [3:0] tx_ph_next;
	logic [3:0] tx_bit_reg;
	logic [3:0] tx_bit_next;
	logic [4:0] tx_wait_reg;
	logic [4:0] tx_wait_next;
	logic       tx_irq_reg;
	logic       tx_irq_next;
	logic       first_reg;
	logic       first_next;

	always_comb
	begin
		tx_st_next   = tx_st_reg;
		tx_hold_next = tx_hold_reg;
		tx_full_next = tx_full_reg;
		tx_sh_next   = tx_sh_reg;
		tx_ph_next   = tx_ph_reg;
		tx_bit_next  = tx_bit_reg;
		tx_wait_next = tx_wait_reg;
		tx_irq_next  = tx_irq_reg;
		first_next   = first_reg;
		if (wr_data)
		begin
			tx_hold_next = i_req.wdata;
			tx_full_next = 1'b1;
			tx_irq_next  = 1'b0;
		end
		// Clear first, so a character end in the same cycle still sets
		if (rd_stat && o_status.interrupt_ident_reg == `IDENT_TX)
			tx_irq_next = 1'b0;
		case (tx_st_reg)
			TX_IDLE:
			begin
				if (tx_full_reg)
				begin
					tx_st_next   = TX_WAIT;
					tx_wait_next = 5'h00;
				end
			end
			TX_WAIT:
			begin
				if (tick)
					tx_wait_next = tx_wait_reg + 5'h01;
				// Start lands on tick 8 of the wait while first_reg is set, else on the first tick
				if (tick && (tx_wait_reg + 5'h01 >= `TX_START_MIN
					|| !first_reg))
				begin
					tx_st_next   = TX_SHIFT;
					tx_sh_next   = {1'b1, tx_hold_reg, 1'b0};
					tx_full_next = wr_data;
					tx_ph_next   = 4'h0;
					tx_bit_next  = 4'h0;
					first_next   = 1'b0;
				end
			end
			TX_SHIFT:
			begin
				if (tick)
				begin
					tx_ph_next = tx_ph_reg + 4'h1;
					if (tx_ph_reg == `OVS_LAST)
					begin
						tx_sh_next  = {1'b1, tx_sh_reg[9:1]};
						tx_bit_next = tx_bit_reg + 4'h1;
						if (tx_bit_reg == `BITS_PER_CHAR + 4'h1)
						begin
							tx_st_next   = TX_IDLE;
							tx_wait_next = 5'h00;
							if (!tx_full_reg && !wr_data)
							begin
								tx_irq_next = 1'b1;
								first_next  = 1'b1;
							end
						end
					end
				end
			end
			default:
				tx_st_next = TX_IDLE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			tx_st_reg   <= TX_IDLE;
			tx_hold_reg <= 8'h00;
			tx_full_reg <= 1'b0;
			tx_sh_reg   <= 10'h3ff;
			tx_ph_reg   <= 4'h0;
			tx_bit_reg  <= 4'h0;
			tx_wait_reg <= 5'h00;
			tx_irq_reg  <= 1'b1;
			first_reg   <= 1'b1;
		end
		else
		begin
			tx_st_reg   <= tx_st_next;
			tx_hold_reg <= tx_hold_next;
			tx_full_reg <= tx_full_next;
			tx_sh_reg   <= tx_sh_next;
			tx_ph_reg   <= tx_ph_next;
			tx_bit_reg  <= tx_bit_next;
			tx_wait_reg <= tx_wait_next;
			tx_irq_reg  <= tx_irq_next;
			first_reg   <= first_next;
		end
	end

	// ======================================================================
	// Outputs
	logic       rx_avail;
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;
	assign rx_avail = (rx_cnt_reg != 7'h00);

	always_comb
	begin
		rdata_next = rdata_reg;
		if (rd_data)
			rdata_next = i_fifo_en ? rx_mem[rx_rp_reg] : rx_holding_reg;
		else if (rd_stat)
			rdata_next = o_status.line_status_reg;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign o_rdata   = rdata_reg;
	assign o_tx_line = tx_st_reg == TX_SHIFT ? tx_sh_reg[0] : 1'b1;

	always_comb
	begin
		o_status.rx_ready_flag   = rx_avail;
		o_status.tx_ready_flag   = ~tx_full_reg;
		o_status.rx_irq          = rx_avail & i_rx_en_irq;
		o_status.tx_irq          = tx_irq_reg & i_tx_en_irq;
		o_status.line_status_reg = {1'b0, ~tx_full_reg & (tx_st_reg == TX_IDLE),
			~tx_full_reg, 3'h0, overrun_reg, rx_avail};
		if (o_status.rx_irq)
			o_status.interrupt_ident_reg = `IDENT_RX;
		else if (o_status.tx_irq)
			o_status.interrupt_ident_reg = `IDENT_TX;
		else
			o_status.interrupt_ident_reg = `IDENT_NONE;
	end

endmodule : uart_channel_event_timing

/* tb/uart_channel_event_timing_properties.sv */
// Port-level timing checks for the serial channel event block.
// Assumes a divisor of one, so one 16x tick is one clock.
module uart_evt_props
(
	input wire logic                    i_clk,
	input wire logic                    i_srst,
	input wire uart_evt_pkg::host_req_t i_req,
	input wire logic                    i_fifo_en,
	input wire logic [15:0]             i_divisor,
	input wire logic                    i_rx_en_irq,
	input wire logic                    i_tx_en_irq,
	input wire logic                    i_rx_line,
	input wire logic                    o_tx_line,
	input wire logic [7:0]              o_rdata,
	input wire uart_evt_pkg::chan_status_t o_status
);
	import uart_evt_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic wr_fall;
	assign wr_fall = !i_req.write_strobe_n && i_req.sel_data;

	a_tx_ready_flag_drop: assert property (
		$fell(i_req.write_strobe_n) && wr_fall |=> !o_status.tx_ready_flag)
		else $error("tx ready still high after a data write");
	a_tx_start_win: assert property (
		$fell(i_req.write_strobe_n) && wr_fall && o_status.line_status_reg[6]
		|-> o_tx_line[*8] ##[1:18] !o_tx_line)
		else $error("start bit outside its window");
	a_tx_ready_flag_back: assert property (
		$fell(o_status.tx_ready_flag) |-> ##[1:400] o_status.tx_ready_flag)
		else $error("tx ready never came back");
	a_wr_irq_clr: assert property (
		$fell(i_req.write_strobe_n) && wr_fall |-> ##[1:7] !o_status.tx_irq)
		else $error("tx interrupt not cleared by write");
	a_st_irq_clr: assert property (
		$fell(i_req.read_strobe_n) && i_req.sel_status
		&& o_status.interrupt_ident_reg == 4'h2 |-> ##[1:7] !o_status.tx_irq)
		else $error("tx interrupt not cleared by status read");
	a_rd_irq_clr: assert property (
		$fell(i_req.read_strobe_n) && i_req.sel_data && !i_fifo_en
		&& o_status.rx_irq |-> ##[1:7] !o_status.rx_irq)
		else $error("rx interrupt not cleared by data read");
	a_rx_ready_flag_clr: assert property (
		$fell(i_req.read_strobe_n) && i_req.sel_data && !i_fifo_en
		|-> ##[1:100] !o_status.rx_ready_flag)
		else $error("rx ready not cleared by data read");
	a_rx_ready_flag_stop: assert property (
		$rose(o_status.rx_ready_flag) |-> i_rx_line && $past(i_rx_line))
		else $error("rx ready rose outside the stop bit");
	a_rx_irq_set: assert property (
		$rose(o_status.rx_ready_flag) && i_rx_en_irq |-> ##[0:2] o_status.rx_irq)
		else $error("rx interrupt late after stop bit");
	a_tx_irq_idle: assert property (
		$rose(o_status.tx_irq) |-> o_tx_line && $past(o_tx_line))
		else $error("tx interrupt rose while the line was busy");
endmodule : uart_evt_props

bind uart_channel_event_timing uart_evt_props i_props (.i_clk, .i_srst, .i_req, .i_fifo_en,
	.i_divisor, .i_rx_en_irq, .i_tx_en_irq, .i_rx_line, .o_tx_line, .o_rdata, .o_status);

/* tb/serial_line_partner.sv */
// Far end of the serial line: sends 8N1 characters, captures transmitted ones.
// Assumes sixteen clocks per bit.
module serial_line_partner
(
	input  wire logic i_clk,
	input  wire logic i_tx_line,
	output logic      o_rx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_q[$];
	logic [7:0] sh;
	initial o_rx_line = 1'b1;

	task automatic send(input logic [7:0] d);
		logic [9:0] fr;
		fr = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge i_clk);
			o_rx_line <= fr[i];
			repeat (15) @(posedge i_clk);
		end
	endtask : send

	// Mid-bit sampling, LSB first
	initial forever
	begin
		@(negedge i_tx_line);
		repeat (8) @(posedge i_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (16) @(posedge i_clk);
			sh[i] = i_tx_line;
		end
		repeat (16) @(posedge i_clk);
		if (i_tx_line === 1'b1)
			got_q.push_back(sh);
	end
endmodule : serial_line_partner

/* tb/tb_uart_channel_event_timing.sv */
// Self-checking bench for the serial channel event block.
// Assumes the partner model on the serial line and a divisor of one.
module tb_uart_channel_event_timing;
	timeunit 1ns;
	timeprecision 1ns;
	import uart_evt_pkg::*;
	typedef struct packed { logic f; logic [7:0] d; } row_t;
	row_t rows[6] = '{'{1'b0, 8'ha5}, '{1'b1, 8'h3c}, '{1'b0, 8'h00},
		'{1'b1, 8'hff}, '{1'b0, 8'h80}, '{1'b1, 8'h01}};
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	host_req_t req = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
	logic fifo_en = 1'b0;
	logic tx_en = 1'b1;
	logic rx_line, tx_line;
	logic [7:0] rdata;
	chan_status_t st;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;

	uart_channel_event_timing i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_req(req),
		.i_fifo_en(fifo_en), .i_divisor(16'h0001), .i_rx_en_irq(1'b1), .i_tx_en_irq(tx_en),
		.i_rx_line(rx_line), .o_tx_line(tx_line), .o_rdata(rdata), .o_status(st));
	serial_line_partner i_partner (.i_clk(i_clk), .i_tx_line(tx_line), .o_rx_line(rx_line));

	initial forever #5 i_clk = ~i_clk;

	task automatic conclude;
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			conclude();
		end
	end

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic g, input logic e);
		chk_byte({7'h00, g}, {7'h00, e});
	endtask : chk_bit

	task automatic strobe(input logic rd, input logic sd, input logic [7:0] wd);
		@(posedge i_clk);
		req <= '{!rd, rd, sd, !sd, wd};
		repeat (2) @(posedge i_clk);
		req.read_strobe_n <= 1'b1;
		req.write_strobe_n <= 1'b1;
		@(posedge i_clk);
		#1;
	endtask : strobe

	task automatic wait_tx(input int n, input logic [7:0] e);
		for (int k = 0; k < 600 && i_partner.got_q.size() < n; k++)
			@(posedge i_clk);
		chk_byte(i_partner.got_q.size() > 0 ? i_partner.got_q.pop_front() : 8'hxx, e);
		// Let the stop bit finish so the end-of-character flags have settled
		repeat (12) @(posedge i_clk);
		#1;
	endtask : wait_tx

	// ======================================================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		#1;
		chk_bit(st.tx_ready_flag, 1'b1);
		chk_bit(st.rx_ready_flag, 1'b0);
		chk_bit(tx_line, 1'b1);
		chk_byte(rdata, 8'h00);
		chk_byte({4'h0, st.interrupt_ident_reg}, 8'h02);
		chk_byte(st.line_status_reg, 8'h60);
		$display("test reset done");
		foreach (rows[i])
		begin
			fifo_en <= rows[i].f;
			i_partner.send(rows[i].d);
			#1;
			chk_bit(st.rx_ready_flag, 1'b1);
			chk_bit(st.rx_irq, 1'b1);
			chk_byte({4'h0, st.interrupt_ident_reg}, 8'h04);
			if (!rows[i].f)
				repeat (2) @(posedge i_clk);
			strobe(1'b1, 1'b1, 8'h00);
			chk_byte(rdata, rows[i].d);
			chk_bit(st.rx_ready_flag, 1'b0);
			strobe(1'b0, 1'b1, ~rows[i].d);
			wait_tx(1, ~rows[i].d);
			chk_bit(st.tx_irq, 1'b1);
			$display("test row %0d done", i);
		end
		strobe(1'b0, 1'b1, 8'h5a);
		// A second write only once the holding byte has moved to the shifter
		for (int k = 0; k < 40 && !st.tx_ready_flag; k++)
			@(posedge i_clk);
		strobe(1'b0, 1'b1, 8'hc3);
		chk_bit(st.tx_ready_flag, 1'b0);
		wait_tx(1, 8'h5a);
		wait_tx(1, 8'hc3);
		$display("test back to back done");
		repeat (20) @(posedge i_clk);
		strobe(1'b1, 1'b0, 8'h00);
		chk_bit(st.tx_irq, 1'b0);
		chk_byte({6'h00, rdata[6:5]}, 8'h03);
		tx_en <= 1'b0;
		strobe(1'b0, 1'b1, 8'h96);
		wait_tx(1, 8'h96);
		chk_bit(st.tx_irq, 1'b0);
		$display("test status and gate done");
		fifo_en <= 1'b0;
		i_partner.send(8'h11);
		i_partner.send(8'h22);
		strobe(1'b1, 1'b0, 8'h00);
		chk_byte(rdata & 8'h03, 8'h03);
		strobe(1'b1, 1'b1, 8'h00);
		chk_byte(rdata, 8'h22);
		strobe(1'b1, 1'b0, 8'h00);
		chk_byte(rdata & 8'h03, 8'h00);
		$display("test overrun done");
		conclude();
	end
endmodule : tb_uart_channel_event_timing
